// [bench/slc_panel_model.sv]
`timescale 1ns/1ns
// passive panel: reports how many lines carry segment drive
module slc_panel_model
(
  input  wire logic        drivePowerOn,
  input  wire logic [31:0] panelDriveLineEnable,
  input  wire logic [3:0]  backplaneLineEnable,
  output logic      [5:0]  driveLineCount,
  output logic             panelEnergized
);
  // count segment lines wired as drivers, the rest are ports
  always_comb
  begin
    driveLineCount = 6'h0;
    for (int i = 0; i < 32; i++)
    begin
      driveLineCount = driveLineCount + 6'(panelDriveLineEnable[i]);
    end
  end
  // glass only lights with supply on and a common driven
  assign panelEnergized = drivePowerOn && (backplaneLineEnable != 4'h0);
endmodule

// [bench/slc_top_chk.sv]
`timescale 1ns/1ns
// watches bus answers and applied controls at the top ports
module slc_top_chk
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        standbyMode,
  input wire logic        controllerRun,
  input wire logic        operatingTick,
  input wire logic [1:0]  dutySelect,
  input wire logic [3:0]  backplaneLineEnable,
  input wire logic [31:0] panelDriveLineEnable,
  input wire logic        expansionPinsOn,
  input wire logic        showRamData,
  input wire logic        drivePowerOn,
  input wire logic        boostRun,
  input wire logic        chargeConnect
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // bus answers
  AST_READY_ONE: assert property (pready |=> !pready) else $error("ready too long");
  AST_READY_CAUSE: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("ready without access");
  AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  ////////////////////////////////////////
  // applied controls
  AST_POWER_GATE: assert property (!controllerRun |-> !drivePowerOn)
    else $error("power on while halted");
  AST_STANDBY_OFF: assert property (standbyMode |=> !drivePowerOn && !boostRun)
    else $error("supply on in standby");
  AST_HALT_QUIET: assert property (!controllerRun [*2] |-> !operatingTick && !showRamData
    && panelDriveLineEnable == 32'h0 && backplaneLineEnable == 4'h0) else $error("active halted");
  AST_DUTY_COMMONS: assert property (backplaneLineEnable != 4'h0 && backplaneLineEnable != 4'hf
    |-> backplaneLineEnable == 4'((5'h2 << dutySelect) - 5'h1)) else $error("commons vs duty");
  AST_SPAN_SHAPE: assert property (panelDriveLineEnable inside {32'h0, 32'hff000000,
    32'hffff0000, 32'hffffff00, 32'hffffffff}) else $error("bad driver span");
  AST_EXPANSION_PORTS: assert property (expansionPinsOn |-> panelDriveLineEnable == 32'h0)
    else $error("driver during expansion");
  AST_CHARGE_STANDBY: assert property (standbyMode [*2] |-> !chargeConnect)
    else $error("charge in standby");
  // main scenarios
  cover property (pready && pslverr);
  cover property (expansionPinsOn);
  cover property (drivePowerOn && boostRun);
endmodule

bind slc_top slc_top_chk i_chk
(
  .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .standbyMode(standbyMode), .controllerRun(controllerRun),
  .operatingTick(operatingTick), .dutySelect(dutySelect),
  .backplaneLineEnable(backplaneLineEnable), .panelDriveLineEnable(panelDriveLineEnable),
  .expansionPinsOn(expansionPinsOn), .showRamData(showRamData), .drivePowerOn(drivePowerOn),
  .boostRun(boostRun), .chargeConnect(chargeConnect)
);

// [bench/test_segment_lcd_control_config.sv]
`timescale 1ns/1ns
// drives the register bus and checks the applied panel controls
module test_segment_lcd_control_config;
  logic        clock, rstn, psel, penable, pwrite, standbyMode, er;
  logic        subClockTick = 1'b0;
  logic        pready, pslverr, controllerRun, operatingTick, expansionPinsOn, showRamData;
  logic        drivePowerOn, waveformTypeB, boostRun, chargeConnect, panelEnergized;
  logic [1:0]  dutySelect;
  logic [2:0]  subDiv = 3'h0;
  logic [3:0]  pstrb, backplaneLineEnable;
  logic [5:0]  driveLineCount;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, panelDriveLineEnable, rd;
  int          badCount, checkCount, cycles, p, k, n;
  int          subCode[4] = '{0, 1, 2, 6};
  int          subGap[4] = '{5, 10, 20, 20};

  slc_top i_dut
  (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standbyMode(standbyMode), .subClockTick(subClockTick),
    .controllerRun(controllerRun), .operatingTick(operatingTick), .dutySelect(dutySelect),
    .backplaneLineEnable(backplaneLineEnable), .panelDriveLineEnable(panelDriveLineEnable),
    .expansionPinsOn(expansionPinsOn), .showRamData(showRamData),
    .drivePowerOn(drivePowerOn), .waveformTypeB(waveformTypeB), .boostRun(boostRun),
    .chargeConnect(chargeConnect)
  );
  slc_panel_model i_panel
  (
    .drivePowerOn(drivePowerOn), .panelDriveLineEnable(panelDriveLineEnable),
    .backplaneLineEnable(backplaneLineEnable), .driveLineCount(driveLineCount),
    .panelEnergized(panelEnergized)
  );
  ////////////////////////////////////////
  always #5 clock = ~clock;
  // subclock pulse every fifth cycle; cycle budget cuts hangs
  always @(posedge clock)
  begin
    subDiv <= (subDiv == 3'h4) ? 3'h0 : subDiv + 3'h1;
    subClockTick <= (subDiv == 3'h4);
    cycles++;
    if (cycles == 60000)
    begin
      badCount++;
      tallyAndFinish();
    end
  end
  ////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      badCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    if (t == 50) badCount++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle();
    repeat (8) @(negedge clock);
  endtask
  // cycles between two operating ticks
  task automatic tickGap();
    n = 0;
    while (operatingTick !== 1'b1 && n < 2000)
    begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    p = 1;
    while (operatingTick !== 1'b1 && p < 2000)
    begin
      @(negedge clock);
      p++;
    end
  endtask
  function automatic logic [31:0] spanMask(input logic [3:0] s);
    if (s[3]) return 32'hffffffff;
    if (s[2:1] == 2'h3) return 32'hffffff00;
    if (s[2:1] == 2'h2) return 32'hffff0000;
    if (s[2:1] == 2'h1) return 32'hff000000;
    return 32'h0;
  endfunction
  // high cycles of the split-resistor connect over four frames
  function automatic int chargeHigh(input logic [3:0] c);
    if (c == 4'h0) return 256;
    if (c < 4'h7) return 32 * c;
    if (c == 4'h7) return 0;
    return c[2] ? 8 : 16;
  endfunction
  task tallyAndFinish();
    if (badCount == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    {clock, rstn, psel, penable, pwrite, standbyMode} = 6'h00;
    paddr = 18'h00000;
    pwdata = 32'h0000_0000;
    badCount = 0;
    checkCount = 0;
    pstrb = 4'hf;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    apb(0, slc_pkg::PORT_CTL_ADDR, 8'h0);
    check(rd, 32'h00);
    apb(0, slc_pkg::CTL_ADDR, 8'h0);
    check(rd, 32'h80);
    apb(0, slc_pkg::CTL_TWO_ADDR, 8'h0);
    check(rd, 32'h60);
    apb(1, 18'h00010, 8'hff);
    check({er, rd}, 33'h100000000);
    apb(1, slc_pkg::PORT_CTL_ADDR, 8'ha5);
    apb(0, slc_pkg::PORT_CTL_ADDR, 8'h0);
    check({er, rd}, 33'ha5);
    // a write with the low byte strobe off leaves the register alone
    pstrb <= 4'h0;
    apb(1, slc_pkg::PORT_CTL_ADDR, 8'h5a);
    pstrb <= 4'hf;
    apb(0, slc_pkg::PORT_CTL_ADDR, 8'h0);
    check({er, rd}, 33'ha5);
    apb(1, slc_pkg::CTL_ADDR, 8'h38);
    for (k = 0; k < 16; k++)
    begin
      apb(1, slc_pkg::PORT_CTL_ADDR, 8'(k));
      settle();
      check(panelDriveLineEnable, spanMask(4'(k)));
      check(driveLineCount, $countones(spanMask(4'(k))));
    end
    for (k = 0; k < 8; k++)
    begin
      apb(1, slc_pkg::PORT_CTL_ADDR, {k[2:0], 5'h08});
      settle();
      check(dutySelect, k[2:1]);
      check(backplaneLineEnable, k[0] ? 4'hf : 4'((5'h2 << k[2:1]) - 5'h1));
    end
    // expansion turns on with an all-zero span and off once its select bit is cleared
    apb(1, slc_pkg::PORT_CTL_ADDR, 8'h10);
    settle();
    check({expansionPinsOn, panelDriveLineEnable}, 33'h100000000);
    apb(1, slc_pkg::PORT_CTL_ADDR, 8'h08);
    settle();
    check(expansionPinsOn, 1'b0);
    apb(1, slc_pkg::CTL_ADDR, 8'h78);
    apb(1, slc_pkg::CTL_TWO_ADDR, 8'h90);
    settle();
    check({drivePowerOn, boostRun, waveformTypeB, showRamData, panelEnergized}, 5'h1f);
    @(posedge clock);
    standbyMode <= 1'b1;
    settle();
    check({drivePowerOn, boostRun, panelEnergized}, 3'h0);
    @(posedge clock);
    standbyMode <= 1'b0;
    apb(1, slc_pkg::CTL_TWO_ADDR, 8'h00);
    apb(1, slc_pkg::CTL_ADDR, 8'h68);
    settle();
    check({drivePowerOn, showRamData, boostRun, waveformTypeB}, 4'h8);
    apb(1, slc_pkg::CTL_ADDR, 8'h18);
    settle();
    check({controllerRun, drivePowerOn, showRamData, panelDriveLineEnable}, 35'h0);
    apb(0, slc_pkg::PORT_CTL_ADDR, 8'h0);
    check(rd, 32'h08);
    for (k = 0; k < 8; k++)
    begin
      apb(1, slc_pkg::CTL_ADDR, 8'h38 | 8'(k));
      tickGap();
      tickGap();
      check(p, 2 << k);
    end
    for (k = 0; k < 4; k++)
    begin
      apb(1, slc_pkg::CTL_ADDR, 8'h30 | 8'(subCode[k]));
      tickGap();
      tickGap();
      check(p, subGap[k]);
    end
    apb(1, slc_pkg::CTL_ADDR, 8'h38);
    for (k = 0; k < 16; k++)
    begin
      apb(1, slc_pkg::CTL_TWO_ADDR, 8'(k));
      settle();
      n = 0;
      repeat (256)
      begin
        @(negedge clock);
        n = n + int'(chargeConnect === 1'b1);
      end
      check(n, chargeHigh(4'(k)));
    end
    // reset in mid-run brings back the reset values
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    apb(0, slc_pkg::PORT_CTL_ADDR, 8'h0);
    check(rd, 32'h00);
    apb(0, slc_pkg::CTL_ADDR, 8'h0);
    check(rd, 32'h80);
    apb(0, slc_pkg::CTL_TWO_ADDR, 8'h0);
    check({controllerRun, drivePowerOn, rd}, 34'h60);
    tallyAndFinish();
  end
endmodule

// [design/slc_clock_divider.sv]
`timescale 1ns/1ns
// makes the operating clock enable from the subclock tick or the system clock
module slc_clock_divider
(
  input  wire logic       clock,
  input  wire logic       rstSync,
  input  wire logic       run,
  input  wire logic       subClockTick,
  input  wire logic [3:0] frameSelect,
  output logic            opTick
);
  logic [slc_pkg::SYS_DIV_WIDTH-1:0] sysCount;
  logic [slc_pkg::SUB_DIV_WIDTH-1:0] subCount;
  logic                              next_opTick;

  // free counters, held cleared while the controller is halted
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
    begin
      sysCount <= '0;
      subCount <= '0;
    end
    else if (!run)
    begin
      sysCount <= '0;
      subCount <= '0;
    end
    else
    begin
      sysCount <= sysCount + 8'h01;
      if (subClockTick)
        subCount <= subCount + 2'h1;
    end
  end

  // tick when the selected low bits of the count are all ones
  always_comb
  begin
    next_opTick = 1'b0;
    if (frameSelect[3])
      next_opTick = &(sysCount | ~((8'h02 << frameSelect[2:0]) - 8'h01));
    else if (subClockTick)
    begin
      case (frameSelect[1:0])
        2'h0:    next_opTick = 1'b1;
        2'h1:    next_opTick = subCount[0];
        default: next_opTick = &subCount;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      opTick <= 1'b0;
    else
      opTick <= next_opTick & run;
  end
endmodule

// [design/slc_pin_map.sv]
`timescale 1ns/1ns
// decodes segment pin use and common pin use
module slc_pin_map
(
  input  wire logic [1:0]  duty,
  input  wire logic        commonParallel,
  input  wire logic        expansionSelect,
  input  wire logic [3:0]  span,
  output logic      [31:0] segDriver,
  output logic             expansionOn,
  output logic      [3:0]  commonDrive
);
  logic [3:0] commonUsed;

  // driver span, bit 31 is the highest segment pin
  always_comb
  begin
    segDriver   = 32'h0000_0000;
    expansionOn = 1'b0;
    if (!expansionSelect)
    begin
      casez (span)
        4'b1???: segDriver = 32'hffff_ffff;
        4'b011?: segDriver = 32'hffff_ff00;
        4'b010?: segDriver = 32'hffff_0000;
        4'b001?: segDriver = 32'hff00_0000;
        default: segDriver = 32'h0000_0000;
      endcase
    end
    else if (span == 4'h0)
      expansionOn = 1'b1;
  end

  // commons used at the duty, unused ones join in parallel on request
  always_comb
  begin
    case (duty)
      2'h0:    commonUsed = 4'h1;
      2'h1:    commonUsed = 4'h3;
      2'h2:    commonUsed = 4'h7;
      default: commonUsed = 4'hf;
    endcase
    commonDrive = commonParallel ? 4'hf : commonUsed;
  end
endmodule

// [design/slc_pkg.sv]
package slc_pkg;
  // register indexes as printed; byte address is four times the index
  localparam logic [15:0] PORT_CTL_INDEX = 16'hffc0;
  localparam logic [15:0] CTL_INDEX      = 16'hffc1;
  localparam logic [15:0] CTL_TWO_INDEX  = 16'hffc2;
  localparam int          ADDR_WIDTH     = 18;
  localparam logic [17:0] PORT_CTL_ADDR  = {PORT_CTL_INDEX, 2'b00};
  localparam logic [17:0] CTL_ADDR       = {CTL_INDEX, 2'b00};
  localparam logic [17:0] CTL_TWO_ADDR   = {CTL_TWO_INDEX, 2'b00};

  // reset values
  localparam logic [7:0] PORT_CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET      = 8'h80;
  localparam logic [7:0] CTL_TWO_RESET  = 8'h60;

  // port control fields
  localparam int DUTY_MSB      = 7;
  localparam int DUTY_LSB      = 6;
  localparam int COMMON_PAR    = 5;
  localparam int EXPANSION_SEL = 4;
  localparam int SPAN_MSB      = 3;
  localparam int SPAN_LSB      = 0;

  // control fields
  localparam int POWER_SWITCH  = 6;
  localparam int FUNCTION_ON   = 5;
  localparam int SHOW_RAM      = 4;
  localparam int FRAME_SRC     = 3;
  localparam int FRAME_MSB     = 2;
  localparam int FRAME_LSB     = 0;

  // control two fields
  localparam int WAVEFORM_SEL  = 7;
  localparam int BOOST_SEL     = 4;
  localparam int CHARGE_MSB    = 3;
  localparam int CHARGE_LSB    = 0;

  // duty encodings
  typedef enum logic [1:0] {
    SLC_DUTY_STATIC  = 2'h0,
    SLC_DUTY_HALF    = 2'h1,
    SLC_DUTY_THIRD   = 2'h2,
    SLC_DUTY_QUARTER = 2'h3
  } slc_duty_t;

  // charge pulse phase counter width (one frame of 32 operating ticks)
  localparam int CHARGE_PHASE_WIDTH = 5;
  localparam logic [3:0] CHARGE_NEVER = 4'h7;

  // system clock divider width: divide by 2 up to 256
  localparam int SYS_DIV_WIDTH = 8;
  localparam int SUB_DIV_WIDTH = 2;
endpackage

// [design/slc_top.sv]
`timescale 1ns/1ns
module slc_top
(
  input  wire logic        clock,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // chip state
  input  wire logic        standbyMode,
  input  wire logic        subClockTick,
  // controls toward the waveform generator and supply
  output logic             controllerRun,
  output logic             operatingTick,
  output logic      [1:0]  dutySelect,
  output logic      [3:0]  backplaneLineEnable,
  output logic      [31:0] panelDriveLineEnable,
  output logic             expansionPinsOn,
  output logic             showRamData,
  output logic             drivePowerOn,
  output logic             waveformTypeB,
  output logic             boostRun,
  output logic             chargeConnect
);
  ////////////////////////////////////////////////////////////////////
  // reset synchroniser
  logic                                   rstMeta;
  logic                                   rstSync;

  // bus decode and read path
  logic                                   accessDone;
  logic                                   writeTaken;
  logic                                   hitPort;
  logic                                   hitCtl;
  logic                                   hitCtlTwo;
  logic                                   hitAny;
  logic [7:0]                             readByte;

  // software registers and the copies the controller works from
  logic [7:0]                             panelPortControl;
  logic [7:0]                             panelControl;
  logic [7:0]                             panelControlTwo;
  logic [7:0]                             portApplied;
  logic [7:0]                             ctlApplied;
  logic [7:0]                             ctlTwoApplied;

  // controller timing and decode results
  logic                                   run;
  logic                                   opTick;
  logic [31:0]                            next_segEnable;
  logic                                   next_expansion;
  logic [3:0]                             next_commonEnable;
  logic [slc_pkg::CHARGE_PHASE_WIDTH-1:0] chargePhase;
  logic                                   next_chargeConnect;

  ////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // address decode; registers sit at four times their index
  assign hitPort    = (paddr == slc_pkg::PORT_CTL_ADDR);
  assign hitCtl     = (paddr == slc_pkg::CTL_ADDR);
  assign hitCtlTwo  = (paddr == slc_pkg::CTL_TWO_ADDR);
  assign hitAny     = hitPort | hitCtl | hitCtlTwo;

  // access completes on the cycle pready is shown high
  assign accessDone = psel & penable & pready;
  assign writeTaken = accessDone & pwrite & pstrb[0];

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  // error answer for unmapped addresses
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      pslverr <= 1'b0;
    else
      pslverr <= psel & penable & ~pready & ~hitAny;
  end

  ////////////////////////////////////////////////////////////////////
  // read mux, byte data in the low lane
  always_comb
  begin
    readByte = 8'h00;
    if (hitPort)
      readByte = panelPortControl;
    else if (hitCtl)
      readByte = panelControl;
    else if (hitCtlTwo)
      readByte = panelControlTwo;
  end

  // read data loads in the wait cycle and clears once the access ends
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      prdata <= 32'h0000_0000;
    else if (psel & penable & ~pready & ~pwrite)
      prdata <= {24'h00_0000, readByte};
    else if (accessDone)
      prdata <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////
  // software registers; a halt keeps their contents
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      panelPortControl <= slc_pkg::PORT_CTL_RESET;
    else if (writeTaken & hitPort & ~pslverr)
      panelPortControl <= pwdata[7:0];
  end

  // control: power, function, display data and frame clock
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      panelControl <= slc_pkg::CTL_RESET;
    else if (writeTaken & hitCtl & ~pslverr)
      panelControl <= pwdata[7:0];
  end

  // control two: waveform, supply source and charge pulse duty
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      panelControlTwo <= slc_pkg::CTL_TWO_RESET;
    else if (writeTaken & hitCtlTwo & ~pslverr)
      panelControlTwo <= pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////
  // controller runs only while the function bit is set
  assign run = panelControl[slc_pkg::FUNCTION_ON];

  // applied copies follow the registers at each operating tick;
  // while halted they follow at once so a restart uses fresh values
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
    begin
      portApplied   <= slc_pkg::PORT_CTL_RESET;
      ctlApplied    <= slc_pkg::CTL_RESET;
      ctlTwoApplied <= slc_pkg::CTL_TWO_RESET;
    end
    else if (opTick | ~run)
    begin
      portApplied   <= panelPortControl;
      ctlApplied    <= panelControl;
      ctlTwoApplied <= panelControlTwo;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // operating clock enable from subclock or system clock
  // the divider reads the live register so a new rate starts at once
  slc_clock_divider clockDivider
  (
    .clock        (clock),
    .rstSync      (rstSync),
    .run          (run),
    .subClockTick (subClockTick),
    .frameSelect  (panelControl[slc_pkg::FRAME_SRC:slc_pkg::FRAME_LSB]),
    .opTick       (opTick)
  );

  ////////////////////////////////////////////////////////////////////
  // pin use decode from the applied port control
  slc_pin_map pinMap
  (
    .duty            (portApplied[slc_pkg::DUTY_MSB:slc_pkg::DUTY_LSB]),
    .commonParallel  (portApplied[slc_pkg::COMMON_PAR]),
    .expansionSelect (portApplied[slc_pkg::EXPANSION_SEL]),
    .span            (portApplied[slc_pkg::SPAN_MSB:slc_pkg::SPAN_LSB]),
    .segDriver       (next_segEnable),
    .expansionOn     (next_expansion),
    .commonDrive     (next_commonEnable)
  );

  ////////////////////////////////////////////////////////////////////
  // pin and duty outputs; a halted controller drives no pins, the duty select still follows
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
    begin
      dutySelect           <= slc_pkg::SLC_DUTY_STATIC;
      backplaneLineEnable  <= 4'h0;
      panelDriveLineEnable <= 32'h0000_0000;
      expansionPinsOn      <= 1'b0;
    end
    else
    begin
      dutySelect           <= portApplied[slc_pkg::DUTY_MSB:slc_pkg::DUTY_LSB];
      backplaneLineEnable  <= run ? next_commonEnable : 4'h0;
      panelDriveLineEnable <= run ? next_segEnable : 32'h0000_0000;
      // illegal expansion plus span leaves all segment pins as ports
      expansionPinsOn      <= run & next_expansion;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // display data and waveform selection
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
    begin
      showRamData   <= 1'b0;
      waveformTypeB <= 1'b0;
    end
    else
    begin
      showRamData   <= run & ctlApplied[slc_pkg::SHOW_RAM];
      // waveform choice is not gated, it only shapes the drive
      waveformTypeB <= ctlTwoApplied[slc_pkg::WAVEFORM_SEL];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // drive power: off at once on halt or standby
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      drivePowerOn <= 1'b0;
    else
      drivePowerOn <= ctlApplied[slc_pkg::POWER_SWITCH] & run & ~standbyMode;
  end

  // step-up regulator runs only when chosen as the drive source
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      boostRun <= 1'b0;
    else
      boostRun <= ctlTwoApplied[slc_pkg::BOOST_SEL] & run & ~standbyMode;
  end

  ////////////////////////////////////////////////////////////////////
  // operating tick strobe out, for the waveform generator
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
    begin
      operatingTick <= 1'b0;
      controllerRun <= 1'b0;
    end
    else
    begin
      operatingTick <= opTick;
      controllerRun <= run;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // charge pulse duty: connection window within a 32 tick cycle
  function automatic logic chargeWindow
  (
    input logic [3:0] sel,
    input logic [4:0] phase
  );
    logic on;
    on = 1'b0;
    casez (sel)
      4'b0000: on = 1'b1;
      4'b0111: on = 1'b0;
      4'b0???: on = ({1'b0, phase[4:2]} < sel);
      4'b10??: on = (phase[4:1] == 4'h0);
      default: on = (phase == 5'h00);
    endcase
    return on;
  endfunction

  // phase advances on each operating tick
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      chargePhase <= '0;
    else if (!run)
      chargePhase <= '0;
    else if (opTick)
      chargePhase <= chargePhase + 5'h01;
  end

  // window for the current phase from the applied field
  assign next_chargeConnect =
    chargeWindow(ctlTwoApplied[slc_pkg::CHARGE_MSB:slc_pkg::CHARGE_LSB], chargePhase);

  // connection is held open while halted or in standby
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      chargeConnect <= 1'b0;
    else
      chargeConnect <= run & ~standbyMode & next_chargeConnect;
  end
endmodule
